// >>> logic/ttc_clock_mod.sv
// Purpose: core-clock stop/start modulator
// Assumes: duty in eighths, 1..7
// Notes: period of eight cycles; zero duty keeps clock running
`timescale 1ns/10ps
`default_nettype none
module ttc_clock_mod (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// control
	input wire logic active_in,
	input wire logic [2:0] duty_in,
	// gate
	output logic clk_en_out
);
	logic [2:0] phase_ff;
	logic clk_en_ff;

	// free-running phase restarts each activation
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_ff <= 3'h0;
		end else if (!active_in) begin
			phase_ff <= 3'h0;
		end else begin
			phase_ff <= phase_ff + 3'h1;
		end
	end

	// on for duty of every eight; reserved zero treated as no gating
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_en_ff <= 1'b1;
		end else if (!active_in || duty_in == 3'h0) begin
			clk_en_ff <= 1'b1;
		end else begin
			clk_en_ff <= (phase_ff < duty_in);
		end
	end

	assign clk_en_out = clk_en_ff;
endmodule
`default_nettype wire

// >>> logic/ttc_params.svh
// Purpose: constants for the thermal throttle controller
// Assumes: 40 MHz core clock (25 ns)
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef TTC_PARAMS_SVH
`define TTC_PARAMS_SVH

`define TTC_CLK_PERIOD_PS 25000
`define TTC_FREQ_SWITCH_NS 5000
// frequency change spans roughly 5 us, rounded down to whole cycles
`define TTC_FREQ_SWITCH_CYC ((`TTC_FREQ_SWITCH_NS * 1000) / `TTC_CLK_PERIOD_PS)
`define TTC_HYST_US 100
`define TTC_HYST_CYC ((`TTC_HYST_US * 1000000) / `TTC_CLK_PERIOD_PS)
`define TTC_VSTEP_NS 1000
`define TTC_VSTEP_CYC ((`TTC_VSTEP_NS * 1000) / `TTC_CLK_PERIOD_PS)

// control field positions
`define TTC_CTL_ENABLE_BIT 4
`define TTC_CTL_DUTY_MSB 3
`define TTC_CTL_DUTY_LSB 1
`define TTC_CTL_RESET 5'h0_0
`define TTC_FACTORY_DUTY 3'h3
`define TTC_VSEL_WIDTH 6
`define TTC_MULT_WIDTH 5

`endif

// >>> logic/ttc_pkg.sv
// Purpose: types for the thermal throttle controller
// Assumes: included with ttc_params.svh
// Notes: states use gray codes along the throttle path, except TTC_FREQ_UP back to TTC_NORMAL (all three bits change)
package ttc_pkg;

	typedef enum logic [2:0] {
		TTC_NORMAL = 3'h0,
		TTC_FREQ_DOWN = 3'h1,
		TTC_VOLT_DOWN = 3'h3,
		TTC_REDUCED = 3'h2,
		TTC_VOLT_UP = 3'h6,
		TTC_FREQ_UP = 3'h7
	} ttc_state_e;

	// one operating point
	typedef struct packed {
		logic [5:0] vsel;
		logic [4:0] mult;
	} ttc_oppoint_s;

	// hot line edge interrupt selects
	typedef struct packed {
		logic on_assert;
		logic on_deassert;
	} ttc_edge_sel_s;

endpackage

// >>> logic/ttc_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: single clock, async active-high reset
// Notes: first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module ttc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	// double register against metastability
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			stage1_ff <= RESET_VAL;
			stage2_ff <= RESET_VAL;
		end else begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_out = stage2_ff;
endmodule
`default_nettype wire

// >>> logic/ttc_top.sv
// Purpose: thermal throttle controller, clock gating and freq/voltage
// Assumes: sensor flags and hot line are asynchronous pins
// Assumes: enables, control bits and operating points come from core logic
// Notes: trip latch clears only on reset
// Notes: freq/voltage path and clock gating run side by side
// Notes: hot line is open drain; only our own overtemperature drives it
// Notes: hysteresis reloads on every hot cycle, so short dips do not release
`timescale 1ns/10ps
`default_nettype none
`include "ttc_params.svh"
module ttc_top #(
	parameter int HYST_CYC = `TTC_HYST_CYC,
	parameter int FREQ_CYC = `TTC_FREQ_SWITCH_CYC,
	parameter int VSTEP_CYC = `TTC_VSTEP_CYC,
	parameter int VW = `TTC_VSEL_WIDTH,
	parameter int MW = `TTC_MULT_WIDTH
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// sensor pins
	input wire logic over_temp_in,
	input wire logic catastrophic_temp_in,
	// hot line, open drain
	input wire logic thermal_alarm_n_in,
	output logic thermal_alarm_n_out,
	output logic thermal_alarm_n_oe_out,
	// configuration
	input wire logic gate_throttle_en_in,
	input wire logic fv_throttle_en_in,
	input wire logic [4:0] throttle_control_reg_in,
	input wire ttc_pkg::ttc_edge_sel_s irq_edge_sel_in,
	input wire ttc_pkg::ttc_oppoint_s normal_point_in,
	input wire ttc_pkg::ttc_oppoint_s reduced_point_in,
	// edge interrupt inputs to hold during freq change
	input wire logic edge_irq_in,
	// core side outputs
	output logic core_clk_en_out,
	output logic bus_block_out,
	output logic edge_irq_out,
	output logic alarm_irq_out,
	output logic [MW-1:0] bus_multiplier_out,
	output logic [VW-1:0] voltage_select_code_out,
	output logic throttle_active_out,
	output ttc_pkg::ttc_state_e state_out,
	// trip
	output logic catastrophic_trip_n_out,
	output logic shutdown_out
);
	// synced pin levels and the combined hot condition
	logic over_temp_s;
	logic cat_temp_s;
	logic alarm_pin_n_s;
	logic hot_any;
	logic alarm_prev_ff;
	// sequencer state, timers and the live operating point
	ttc_pkg::ttc_state_e state_ff;
	ttc_pkg::ttc_state_e nxt_state;
	logic [31:0] timer_ff;
	logic [31:0] hyst_ff;
	logic [VW-1:0] vsel_ff;
	logic [MW-1:0] mult_ff;
	// trip latch and interrupt staging
	logic trip_ff;
	logic pend_irq_ff;
	logic irq_out_ff;
	logic alarm_irq_ff;
	// modulator request
	logic gate_active;
	logic [2:0] mod_duty;
	logic mod_active;
	logic clk_en;
	logic fv_busy;

	// one code table entry toward the target; holds once reached
	// used by both ramps so entry and exit step alike
	function automatic logic [VW-1:0] step_toward(
		input logic [VW-1:0] cur,
		input logic [VW-1:0] target
	);
		logic [VW-1:0] res;
		res = cur;
		if (cur > target) begin
			res = cur - {{(VW-1){1'b0}}, 1'b1};
		end else if (cur < target) begin
			res = cur + {{(VW-1){1'b0}}, 1'b1};
		end
		return res;
	endfunction

	// pins cross into the core clock domain
	// the hot wire resets high, its idle level, so no false edge follows reset
	ttc_sync #(.WIDTH(3), .RESET_VAL(3'b100)) u_sync (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in({thermal_alarm_n_in, catastrophic_temp_in, over_temp_in}),
		.sync_out({alarm_pin_n_s, cat_temp_s, over_temp_s})
	);

	// only our own sensor drives the line; echoing an external low back
	// would latch two parts into holding each other hot
	// hot drive on overtemperature
	assign thermal_alarm_n_out = 1'b0;
	assign thermal_alarm_n_oe_out = over_temp_s;

	// a board circuit pulling low throttles us just as our own sensor would
	// external pull low counts as hot
	assign hot_any = over_temp_s | ~alarm_pin_n_s;

	// previous level resets high, the idle level of the line
	// the pulse lags the wire by the two sync stages plus one
	// edge detect on the wire level
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			alarm_prev_ff <= 1'b1;
			alarm_irq_ff <= 1'b0;
		end else begin
			alarm_prev_ff <= alarm_pin_n_s;
			alarm_irq_ff <= (irq_edge_sel_in.on_assert & alarm_prev_ff & ~alarm_pin_n_s)
				| (irq_edge_sel_in.on_deassert & ~alarm_prev_ff & alarm_pin_n_s);
		end
	end
	assign alarm_irq_out = alarm_irq_ff;

	// reload on every hot cycle: a brief cool dip near the limit never
	// releases the reduced point, at the price of a slower return
	// an external low on the wire holds the timer just as our sensor does
	// hysteresis timer reloads while hot, counts down when cool
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			hyst_ff <= 32'h0000_0000;
		end else if (hot_any) begin
			hyst_ff <= 32'(HYST_CYC);
		end else if (hyst_ff != 32'h0000_0000) begin
			hyst_ff <= hyst_ff - 32'h0000_0001;
		end
	end

	// the enable is looked at only in the normal state; dropping it mid-ramp
	// does not abort, which would leave the code off the table's path
	// freq/voltage sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ttc_pkg::TTC_NORMAL: begin
				// wait for hot with the fv path enabled
				if (fv_throttle_en_in && hot_any) begin
					nxt_state = ttc_pkg::TTC_FREQ_DOWN;
				end
			end
			ttc_pkg::TTC_FREQ_DOWN: begin
				if (timer_ff == 32'h0000_0000) begin
					nxt_state = ttc_pkg::TTC_VOLT_DOWN;
				end
			end
			ttc_pkg::TTC_VOLT_DOWN: begin
				// leave only after the last step has settled
				if (vsel_ff == reduced_point_in.vsel[VW-1:0] && timer_ff == 32'h0000_0000) begin
					nxt_state = ttc_pkg::TTC_REDUCED;
				end
			end
			ttc_pkg::TTC_REDUCED: begin
				// cool and hysteresis expired
				if (!hot_any && hyst_ff == 32'h0000_0000) begin
					nxt_state = ttc_pkg::TTC_VOLT_UP;
				end
			end
			ttc_pkg::TTC_VOLT_UP: begin
				// code back at nominal before the clock rises
				if (vsel_ff == normal_point_in.vsel[VW-1:0] && timer_ff == 32'h0000_0000) begin
					nxt_state = ttc_pkg::TTC_FREQ_UP;
				end
			end
			ttc_pkg::TTC_FREQ_UP: begin
				// second stall, same length as the first
				if (timer_ff == 32'h0000_0000) begin
					nxt_state = ttc_pkg::TTC_NORMAL;
				end
			end
			default: begin
				// unused codes fall back to the safe point
				nxt_state = ttc_pkg::TTC_NORMAL;
			end
		endcase
	end

	// one state register for the whole ramp, so outputs never disagree
	// state register
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= ttc_pkg::TTC_NORMAL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// loaded on every state change; in the voltage states it reloads itself,
	// giving one code step every VSTEP_CYC+1 cycles
	// phase timer: freq switch length or voltage step spacing
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			timer_ff <= 32'h0000_0000;
		end else if (nxt_state != state_ff) begin
			if (nxt_state == ttc_pkg::TTC_FREQ_DOWN || nxt_state == ttc_pkg::TTC_FREQ_UP) begin
				timer_ff <= 32'(FREQ_CYC);
			end else begin
				timer_ff <= 32'(VSTEP_CYC);
			end
		end else if (timer_ff != 32'h0000_0000) begin
			timer_ff <= timer_ff - 32'h0000_0001;
		end else if (state_ff == ttc_pkg::TTC_VOLT_DOWN || state_ff == ttc_pkg::TTC_VOLT_UP) begin
			timer_ff <= 32'(VSTEP_CYC);
		end
	end

	// the bus stays open while the code moves; only the clock change stalls it
	// one code entry per step, no bus stall
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			vsel_ff <= '0;
		end else if (state_ff == ttc_pkg::TTC_NORMAL) begin
			vsel_ff <= normal_point_in.vsel[VW-1:0];
		end else if (timer_ff == 32'h0000_0000) begin
			if (state_ff == ttc_pkg::TTC_VOLT_DOWN) begin
				vsel_ff <= step_toward(vsel_ff, reduced_point_in.vsel[VW-1:0]);
			end else if (state_ff == ttc_pkg::TTC_VOLT_UP) begin
				vsel_ff <= step_toward(vsel_ff, normal_point_in.vsel[VW-1:0]);
			end
		end
	end

	// swaps at the end of each stall so the core never runs the new ratio early
	// multiplier: reduced from freq-down end until freq-up end
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mult_ff <= '0;
		end else if (state_ff == ttc_pkg::TTC_NORMAL || nxt_state == ttc_pkg::TTC_NORMAL) begin
			mult_ff <= normal_point_in.mult[MW-1:0];
		end else if (state_ff == ttc_pkg::TTC_FREQ_DOWN && timer_ff == 32'h0000_0000) begin
			mult_ff <= reduced_point_in.mult[MW-1:0];
		end
	end

	// combinational from the state flop, so the stall tracks the state exactly
	// bus blocked only during frequency switch
	assign fv_busy = (state_ff == ttc_pkg::TTC_FREQ_DOWN) || (state_ff == ttc_pkg::TTC_FREQ_UP);
	assign bus_block_out = fv_busy;

	// pending edges leave as a single pulse; two edges in one stall merge,
	// which is harmless for edge-triggered sources
	// latch edges while blocked; set wins over release
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pend_irq_ff <= 1'b0;
			irq_out_ff <= 1'b0;
		end else if (fv_busy) begin
			pend_irq_ff <= pend_irq_ff | edge_irq_in;
			irq_out_ff <= 1'b0;
		end else begin
			pend_irq_ff <= 1'b0;
			irq_out_ff <= pend_irq_ff | edge_irq_in;
		end
	end
	assign edge_irq_out = irq_out_ff;

	// software only reaches the modulator; it has no way into the sequencer
	// gating from hot line or software, never the fv path
	assign gate_active = gate_throttle_en_in & hot_any;
	assign mod_active = gate_active | throttle_control_reg_in[`TTC_CTL_ENABLE_BIT];
	// factory duty wins while thermal throttle engaged
	assign mod_duty = gate_active ? `TTC_FACTORY_DUTY
		: throttle_control_reg_in[`TTC_CTL_DUTY_MSB:`TTC_CTL_DUTY_LSB];

	// one modulator serves both thermal and software requests
	// duty zero falls through to a running clock, the safe reading of reserved
	// stop/start modulator
	ttc_clock_mod u_mod (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.active_in(mod_active),
		.duty_in(mod_duty),
		.clk_en_out(clk_en)
	);

	// set from the synced pin alone: no bus, state or enable can hold it off
	// sticky so a cooling die cannot restart itself unattended
	// trip latch, cleared only by reset
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			trip_ff <= 1'b0;
		end else if (cat_temp_s) begin
			trip_ff <= 1'b1;
		end
	end

	// trip stops the core clock whatever the modulator says
	// throttle_active covers both circuits for status readers
	// outputs
	assign catastrophic_trip_n_out = ~trip_ff;
	assign shutdown_out = trip_ff;
	assign core_clk_en_out = clk_en & ~trip_ff;
	assign bus_multiplier_out = mult_ff;
	assign voltage_select_code_out = vsel_ff;
	assign throttle_active_out = mod_active | (state_ff != ttc_pkg::TTC_NORMAL);
	assign state_out = state_ff;
endmodule
`default_nettype wire

// >>> test/thermal_throttle_control_tb_top.sv
// Purpose: self-checking bench for the throttle controller
// Assumes: short counts for stall, steps and hysteresis
// Notes: board pull and regulator live in the partner model
`timescale 1ns/10ps
`default_nettype none
`include "ttc_params.svh"
module thermal_throttle_control_tb_top;
	logic clk, rst, hot, cat, pull, gate_en, fv_en, eirq, wire_lvl, oe, drv;
	logic clk_en, blk, eirq_o, airq, trip_n, sdn, act;
	logic [4:0] ctl, mult;
	logic [5:0] code;
	ttc_pkg::ttc_edge_sel_s esel;
	ttc_pkg::ttc_oppoint_s npt, rpt;
	ttc_pkg::ttc_state_e st;
	int n_errors, num_checks, bad_steps, cnt, ecnt;
	// control value beside expected clock-on eighths
	logic [8:0] rows [10] = '{9'h121, 9'h142, 9'h163, 9'h184, 9'h1a5,
		9'h1c6, 9'h1e7, 9'h1f7, 9'h108, 9'h0e8};
	ttc_top #(.HYST_CYC(50), .FREQ_CYC(10), .VSTEP_CYC(3)) uut (
		.ref_clk_in(clk), .reset_in(rst), .over_temp_in(hot), .catastrophic_temp_in(cat),
		.thermal_alarm_n_in(wire_lvl), .thermal_alarm_n_out(drv),
		.thermal_alarm_n_oe_out(oe), .gate_throttle_en_in(gate_en),
		.fv_throttle_en_in(fv_en), .throttle_control_reg_in(ctl), .irq_edge_sel_in(esel),
		.normal_point_in(npt), .reduced_point_in(rpt), .edge_irq_in(eirq),
		.core_clk_en_out(clk_en), .bus_block_out(blk), .edge_irq_out(eirq_o),
		.alarm_irq_out(airq), .bus_multiplier_out(mult), .voltage_select_code_out(code),
		.throttle_active_out(act), .state_out(st), .catastrophic_trip_n_out(trip_n),
		.shutdown_out(sdn));
	ttc_vreg_model u_vreg (.ref_clk_in(clk), .code_in(code), .dut_oe_in(oe),
		.dut_level_in(drv), .board_pull_in(pull), .alarm_wire_out(wire_lvl),
		.bad_steps_out(bad_steps));
	// pulse counters, sampled mid-cycle away from the launching edge
	always @(negedge clk) begin
		cnt += (airq === 1'b1);
		ecnt += (eirq_o === 1'b1);
	end
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// clock-on cycles over one eight-cycle period
	task automatic count_on(output int on);
		on = 0;
		repeat (8) begin
			tick(1);
			on += (clk_en === 1'b1);
		end
	endtask
	task automatic wait_st(input ttc_pkg::ttc_state_e s);
		int i;
		for (i = 0; i < 2000 && st !== s; i++) tick(1);
		check(16'(st), 16'(s));
	endtask
	// run needs under 2000 cycles; 10000 means a hang
	initial begin
		#250000;
		n_errors++;
		finish_test();
	end
	initial begin
		int i, on;
		{rst, hot, cat, pull, eirq, gate_en, fv_en} = 7'b1000011;
		ctl = 5'h00;
		esel = 2'b00;
		npt = {6'h14, 5'h10};
		rpt = {6'h11, 5'h0a};
		tick(4);
		rst = 0;
		tick(3);
		for (i = 0; i < 10; i++) begin
			ctl = rows[i][8:4];
			tick(12);
			count_on(on);
			check(16'(on), 16'(rows[i][3:0]));
			check(16'(st), 16'(ttc_pkg::TTC_NORMAL));
		end
		$display("test duty table done");
		fv_en = 0;
		ctl = 5'h1e;
		for (i = 1; i < 4; i++) begin
			esel = 2'(i);
			cnt = 0;
			pull = 1;
			tick(12);
			count_on(on);
			check(16'(on), 16'(`TTC_FACTORY_DUTY));
			pull = 0;
			tick(12);
			check(16'(cnt), (i == 3) ? 16'h2 : 16'h1);
		end
		$display("test hot line done");
		fv_en = 1;
		ctl = 5'h00;
		hot = 1;
		for (i = 0; i < 200 && blk !== 1'b1; i++) tick(1);
		check(16'(st), 16'(ttc_pkg::TTC_FREQ_DOWN));
		ecnt = 0;
		eirq = 1;
		tick(1);
		eirq = 0;
		for (i = 0; i < 200 && blk === 1'b1; i++) tick(1);
		tick(3);
		check(16'(ecnt), 16'h1);
		check(16'(mult), 16'(rpt.mult));
		check(16'(oe), 16'h1);
		wait_st(ttc_pkg::TTC_REDUCED);
		check(16'(code), 16'(rpt.vsel));
		check(16'(act), 16'h1);
		hot = 0;
		tick(40);
		check(16'(st), 16'(ttc_pkg::TTC_REDUCED));
		wait_st(ttc_pkg::TTC_NORMAL);
		check({code, mult}, 16'(npt));
		check(16'(bad_steps), 16'h0);
		$display("test freq voltage done");
		cat = 1;
		tick(4);
		check({trip_n, sdn, blk}, 16'h2);
		cat = 0;
		tick(5);
		check({trip_n, sdn}, 16'h1);
		$display("test trip done");
		rst = 1;
		tick(4);
		check({trip_n, blk, oe}, 16'h4);
		rst = 0;
		tick(2);
		check(16'(code), 16'(npt.vsel));
		check(16'(st), 16'(ttc_pkg::TTC_NORMAL));
		check(16'(act), 16'h0);
		$display("test reset done");
		finish_test();
	end
endmodule
`default_nettype wire

// >>> test/ttc_checker.sv
// Purpose: port assertions for the throttle controller
// Assumes: one clock, reset high
// Notes: stall length tied to the FREQ_CYC parameter
`timescale 1ns/10ps
`default_nettype none
module ttc_checker #(
	parameter int FREQ_CYC = 10,
	parameter int VW = 6
) (
	// watched ports
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic over_temp_in,
	input wire logic catastrophic_temp_in,
	input wire logic fv_throttle_en_in,
	input wire ttc_pkg::ttc_oppoint_s normal_point_in,
	input wire logic thermal_alarm_n_oe_out,
	input wire logic bus_block_out,
	input wire logic edge_irq_out,
	input wire logic [VW-1:0] voltage_select_code_out,
	input wire ttc_pkg::ttc_state_e state_out,
	input wire logic catastrophic_trip_n_out,
	input wire logic shutdown_out,
	input wire logic core_clk_en_out
);
	int blk_cnt_ff;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	// cycles spent in the current bus stall
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			blk_cnt_ff <= 0;
		end else begin
			blk_cnt_ff <= bus_block_out ? blk_cnt_ff + 1 : 0;
		end
	end
	chk_block_in_freq: assert property (bus_block_out == (state_out inside
		{ttc_pkg::TTC_FREQ_DOWN, ttc_pkg::TTC_FREQ_UP})) else $error("stall outside freq change");
	chk_block_len: assert property ($fell(bus_block_out) && !$past(reset_in)
		|-> blk_cnt_ff == FREQ_CYC + 1) else $error("stall length wrong");
	chk_code_step: assert property ($changed(voltage_select_code_out)
		&& !$past(reset_in) && !$past(reset_in, 2)
		|-> voltage_select_code_out == $past(voltage_select_code_out) + VW'(1)
		|| voltage_select_code_out + VW'(1) == $past(voltage_select_code_out))
		else $error("code step wider than one");
	chk_code_quiet: assert property ($changed(voltage_select_code_out)
		&& !$past(reset_in) && !$past(reset_in, 2)
		|-> !bus_block_out && !$past(bus_block_out)) else $error("code moved during stall");
	chk_fv_needs_en: assert property ($rose(bus_block_out)
		&& $past(state_out) == ttc_pkg::TTC_NORMAL |-> $past(fv_throttle_en_in))
		else $error("freq throttle without enable");
	chk_return_order: assert property ($rose(bus_block_out)
		&& $past(state_out) != ttc_pkg::TTC_NORMAL
		|-> voltage_select_code_out == normal_point_in.vsel) else $error("freq raised first");
	chk_hot_drive: assert property (over_temp_in [*3] |-> thermal_alarm_n_oe_out)
		else $error("hot line not driven");
	chk_trip_latch: assert property (catastrophic_temp_in [*4] |-> !catastrophic_trip_n_out)
		else $error("trip late");
	chk_trip_hold: assert property (!catastrophic_trip_n_out |=> !catastrophic_trip_n_out
		&& shutdown_out && !core_clk_en_out) else $error("trip released");
	chk_irq_held: assert property (bus_block_out |-> !edge_irq_out)
		else $error("irq during stall");
endmodule
bind ttc_top ttc_checker #(.FREQ_CYC(FREQ_CYC), .VW(VW)) u_ttc_chk (
	.ref_clk_in(ref_clk_in), .reset_in(reset_in), .over_temp_in(over_temp_in),
	.catastrophic_temp_in(catastrophic_temp_in), .fv_throttle_en_in(fv_throttle_en_in),
	.normal_point_in(normal_point_in), .thermal_alarm_n_oe_out(thermal_alarm_n_oe_out),
	.bus_block_out(bus_block_out), .edge_irq_out(edge_irq_out),
	.voltage_select_code_out(voltage_select_code_out), .state_out(state_out),
	.catastrophic_trip_n_out(catastrophic_trip_n_out), .shutdown_out(shutdown_out),
	.core_clk_en_out(core_clk_en_out));
`default_nettype wire

// >>> test/ttc_vreg_model.sv
// Purpose: regulator and board hot-line model
// Assumes: hot line has a pull-up
// Notes: counts code jumps wider than one entry
`timescale 1ns/10ps
`default_nettype none
module ttc_vreg_model (
	// clock and code
	input wire logic ref_clk_in,
	input wire logic [5:0] code_in,
	// hot line parties
	input wire logic dut_oe_in,
	input wire logic dut_level_in,
	input wire logic board_pull_in,
	output logic alarm_wire_out,
	output int bad_steps_out
);
	logic [5:0] last;
	assign alarm_wire_out = !board_pull_in && (!dut_oe_in || dut_level_in);
	// code followed live; zero means not loaded yet
	initial begin
		bad_steps_out = 0;
		last = 6'h00;
		forever begin
			@(posedge ref_clk_in);
			if (last != 6'h00 && code_in != last && code_in != last + 6'h01
					&& code_in + 6'h01 != last) begin
				bad_steps_out++;
			end
			last = code_in;
		end
	end
endmodule
`default_nettype wire
